// ===== demod_consts.svh
`ifndef DEMOD_CONSTS_SVH
`define DEMOD_CONSTS_SVH

// ==========================================
// Word layout
`define WORD_W 32
`define ADDR_LSB 0
`define ADDR_MSB 4
`define SETUP_ONE_ADDR 5'h09
`define CAL_SETUP_ADDR 5'h0a
`define READBACK_ADDR 5'h08

// ==========================================
// Reset values
`define SETUP_ONE_RST 32'h0100fc89
`define CAL_SETUP_RST 32'h71e0200a

// ==========================================
// Setup one field positions
`define MIX_PD_BIT 5
`define BUF_PD_BIT 7
`define FILT_PD_BIT 8
`define OCAL_PD_BIT 10
`define GAIN_LSB 12
`define GAIN_MSB 16
`define GAIN_MAX 5'h18
`define CORNER_LSB 17
`define CORNER_MSB 24
`define DET_R_BIT 25
`define DET_C_BIT 26
`define FAST_GAIN_BIT 27
`define GAIN_STEP_BIT 28
`define OSC_TEST_BIT 29
`define ATTEN_BIT 31

// ==========================================
// Calibration and readback fields
`define AUTOCAL_BIT 5
`define RB_SEL_LSB 5
`define RB_SEL_MSB 7
`define RB_SEL_SETUP 3'h1
`define RB_SEL_CAL 3'h2
`define RB_LAST_BIT 5'h1f

`endif

// ===== demod_pkg.sv
package demod_pkg;

    // Offset detector bandwidth
    typedef enum logic [1:0]
    {
        DET_BW_10MHZ = 2'h0,
        DET_BW_10KHZ = 2'h1,
        DET_BW_1KHZ = 2'h3
    } det_bw_t;

    // Readback sequencer on the serial clock
    typedef enum logic [1:0]
    {
        LINK_IDLE = 2'h0,
        LINK_SHIFT = 2'h1
    } link_state_t;

endpackage

// ===== level_sync2.sv
`timescale 1ns/10ps

module level_sync2 #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Data
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);

    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_q;

    // First stage is read only by the second
    always_comb
    begin
        next_meta = d_i;
        next_q = meta;
    end

    // Two flops, plain level crossing
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta <= '0;
            q_o <= '0;
        end
        else
        begin
            meta <= next_meta;
            q_o <= next_q;
        end
    end

endmodule

// ===== pin_filter3.sv
`timescale 1ns/10ps

module pin_filter3 #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Pin in, accepted level out
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] level_o
);

    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] next_level;

    // Change accepted only once stages two and three agree
    genvar b;
    generate
        for (b = 0; b < WIDTH; b++)
        begin : g_bit
            always_comb
            begin
                next_level[b] = (s2[b] == s3[b]) ? s3[b] : level_o[b];
            end
        end
    endgenerate

    // Three stage chain
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            level_o <= '0;
        end
        else
        begin
            s1 <= pin_i;
            s2 <= s1;
            s3 <= s2;
            level_o <= next_level;
        end
    end

endmodule

// ===== demod_setup_registers.sv
`include "demod_consts.svh"
`timescale 1ns/10ps

module demod_setup_registers (
    // System clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Serial programming link
    input wire logic ser_clk_i,
    input wire logic ser_data_i,
    input wire logic word_load_edge_i,
    output logic readback_o,
    // Analog status inputs
    input wire logic cal_done_i,
    input wire logic osc_i,
    // Power controls
    output logic mixer_powerdown_o,
    output logic test_buffer_powerdown_o,
    output logic filter_powerdown_o,
    output logic offset_cal_powerdown_o,
    // Gain and filter controls
    output logic [4:0] baseband_gain_code_o,
    output logic [7:0] corner_freq_code_o,
    output logic detector_resistor_bypass_o,
    output logic detector_capacitor_bypass_o,
    output demod_pkg::det_bw_t detector_bw_o,
    output logic fast_gain_enable_o,
    output logic gain_step_double_o,
    output logic osc_test_enable_o,
    output logic output_atten_enable_o,
    // Calibration control
    output logic autocal_start_o
);
    import demod_pkg::*;

    // ==========================================
    // System domain declarations
    logic strobe_lvl;
    logic strobe_prev;
    logic next_strobe_prev;
    logic strobe_rise;
    logic done_lvl;
    logic done_prev;
    logic next_done_prev;
    logic done_rise;
    logic [31:0] setup_one;
    logic [31:0] next_setup_one;
    logic [31:0] cal_setup;
    logic [31:0] next_cal_setup;
    logic [31:0] rb_word;
    logic [31:0] next_rb_word;
    logic rb_toggle;
    logic next_rb_toggle;
    logic [4:0] gain_q;
    logic [4:0] next_gain;
    det_bw_t bw_q;
    det_bw_t next_bw;
    logic [31:0] ser_word;
    logic [4:0] word_addr;

    // ==========================================
    // Link domain declarations
    logic link_rst;
    logic [31:0] shift_in;
    logic [31:0] next_shift_in;
    logic [31:0] rb_shift;
    logic [31:0] next_rb_shift;
    logic [4:0] rb_count;
    logic [4:0] next_rb_count;
    link_state_t link_state;
    link_state_t next_link_state;
    logic rb_seen;
    logic next_rb_seen;
    logic rb_toggle_s;
    logic osc_test_s;
    logic osc_lvl;
    logic next_readback;

    // ==========================================
    // Crossings into the system domain
    pin_filter3 #(
        .WIDTH(2)
    ) u_sys_pins (
        .clk_i(clk_i),
        .rst_i(sys_rst_i),
        .pin_i({cal_done_i, word_load_edge_i}),
        .level_o({done_lvl, strobe_lvl})
    );

    // Edges on the accepted levels
    always_comb
    begin
        next_strobe_prev = strobe_lvl;
        next_done_prev = done_lvl;
        strobe_rise = strobe_lvl & ~strobe_prev;
        done_rise = done_lvl & ~done_prev;
    end

    // Shift word is still once the host stops clocking before the strobe
    assign ser_word = shift_in;
    assign word_addr = ser_word[`ADDR_MSB:`ADDR_LSB];

    // ==========================================
    // Register bank
    always_comb
    begin
        next_setup_one = setup_one;
        next_cal_setup = cal_setup;
        next_rb_word = rb_word;
        next_rb_toggle = rb_toggle;
        // Finished calibration drops the start bit
        if (done_rise)
        begin
            next_cal_setup[`AUTOCAL_BIT] = 1'b0;
        end
        // Strobe edge loads the addressed word; a new start beats the clear
        if (strobe_rise)
        begin
            case (word_addr)
                `SETUP_ONE_ADDR:
                begin
                    // Unused bits are stored but feed only the readback word
                    next_setup_one = ser_word;
                end
                `CAL_SETUP_ADDR:
                begin
                    next_cal_setup = ser_word;
                end
                `READBACK_ADDR:
                begin
                    case (ser_word[`RB_SEL_MSB:`RB_SEL_LSB])
                        `RB_SEL_SETUP: next_rb_word = setup_one;
                        `RB_SEL_CAL: next_rb_word = cal_setup;
                        default: next_rb_word = 32'h00000000;
                    endcase
                    next_rb_toggle = ~rb_toggle;
                end
                default:
                begin
                    next_rb_toggle = rb_toggle;
                end
            endcase
        end
    end

    // Derived controls
    always_comb
    begin
        next_gain = setup_one[`GAIN_MSB:`GAIN_LSB];
        // Codes above the top step are held at the top step
        if (next_gain > `GAIN_MAX)
        begin
            next_gain = `GAIN_MAX;
        end
        // Resistor bit low bypasses the whole RC
        if (!setup_one[`DET_R_BIT])
        begin
            next_bw = DET_BW_10MHZ;
        end
        else if (setup_one[`DET_C_BIT])
        begin
            next_bw = DET_BW_1KHZ;
        end
        else
        begin
            next_bw = DET_BW_10KHZ;
        end
    end

    // System state registers
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            strobe_prev <= 1'b0;
            done_prev <= 1'b0;
            setup_one <= `SETUP_ONE_RST;
            cal_setup <= `CAL_SETUP_RST;
            rb_word <= 32'h00000000;
            rb_toggle <= 1'b0;
            gain_q <= 5'(`SETUP_ONE_RST >> `GAIN_LSB);
            bw_q <= DET_BW_10MHZ;
        end
        else
        begin
            strobe_prev <= next_strobe_prev;
            done_prev <= next_done_prev;
            setup_one <= next_setup_one;
            cal_setup <= next_cal_setup;
            rb_word <= next_rb_word;
            rb_toggle <= next_rb_toggle;
            gain_q <= next_gain;
            bw_q <= next_bw;
        end
    end

    // ==========================================
    // Control outputs
    assign mixer_powerdown_o = setup_one[`MIX_PD_BIT];
    assign test_buffer_powerdown_o = setup_one[`BUF_PD_BIT];
    assign filter_powerdown_o = setup_one[`FILT_PD_BIT];
    assign offset_cal_powerdown_o = setup_one[`OCAL_PD_BIT];
    assign baseband_gain_code_o = gain_q;
    assign corner_freq_code_o = setup_one[`CORNER_MSB:`CORNER_LSB];
    assign detector_resistor_bypass_o = setup_one[`DET_R_BIT];
    assign detector_capacitor_bypass_o = setup_one[`DET_C_BIT];
    assign detector_bw_o = bw_q;
    assign fast_gain_enable_o = setup_one[`FAST_GAIN_BIT];
    assign gain_step_double_o = setup_one[`GAIN_STEP_BIT];
    assign osc_test_enable_o = setup_one[`OSC_TEST_BIT];
    assign output_atten_enable_o = setup_one[`ATTEN_BIT];
    assign autocal_start_o = cal_setup[`AUTOCAL_BIT];

    // ==========================================
    // Crossings into the link domain
    // Link reset only takes effect while the serial clock runs
    level_sync2 #(
        .WIDTH(2)
    ) u_link_sync (
        .clk_i(ser_clk_i),
        .rst_i(1'b0),
        .d_i({sys_rst_i, setup_one[`OSC_TEST_BIT]}),
        .q_o({link_rst, osc_test_s})
    );

    // Request toggle settles long before the host's idle clock; a sync stage
    // here would push the idle clock two serial edges late
    assign rb_toggle_s = rb_toggle;

    // Oscillator is only seen while the serial clock runs
    pin_filter3 #(
        .WIDTH(1)
    ) u_osc_pin (
        .clk_i(ser_clk_i),
        .rst_i(link_rst),
        .pin_i(osc_i),
        .level_o(osc_lvl)
    );

    // ==========================================
    // Link sequencer
    always_comb
    begin
        next_shift_in = shift_in;
        next_rb_shift = rb_shift;
        next_rb_count = rb_count;
        next_link_state = link_state;
        next_rb_seen = rb_seen;
        next_readback = 1'b0;
        case (link_state)
            LINK_IDLE:
            begin
                if (rb_toggle_s != rb_seen)
                begin
                    // Idle clock: word loads, nothing shifts
                    next_rb_seen = rb_toggle_s;
                    next_rb_shift = rb_word;
                    next_rb_count = 5'h00;
                    next_link_state = LINK_SHIFT;
                end
                else
                begin
                    // LSB arrives first and ends at bit zero
                    next_shift_in = {ser_data_i, shift_in[31:1]};
                end
            end
            LINK_SHIFT:
            begin
                next_readback = rb_shift[0];
                next_rb_shift = {1'b0, rb_shift[31:1]};
                next_rb_count = rb_count + 5'h01;
                if (rb_count == `RB_LAST_BIT)
                begin
                    next_link_state = LINK_IDLE;
                end
            end
            default:
            begin
                next_link_state = LINK_IDLE;
            end
        endcase
        // Oscillator test replaces readback data on the pin
        if (osc_test_s)
        begin
            next_readback = osc_lvl;
        end
    end

    // Link state registers
    always_ff @(posedge ser_clk_i)
    begin
        if (link_rst)
        begin
            shift_in <= 32'h00000000;
            rb_shift <= 32'h00000000;
            rb_count <= 5'h00;
            link_state <= LINK_IDLE;
            rb_seen <= 1'b0;
            readback_o <= 1'b0;
        end
        else
        begin
            shift_in <= next_shift_in;
            rb_shift <= next_rb_shift;
            rb_count <= next_rb_count;
            link_state <= next_link_state;
            rb_seen <= next_rb_seen;
            readback_o <= next_readback;
        end
    end

endmodule

// ===== demod_setup_registers_monitor.sv
`timescale 1ns/10ps

// ==========================================
// Port checker
module demod_setup_registers_monitor (
    // Clock, reset, link and calibration pins
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic word_load_edge_i,
    input wire logic cal_done_i,
    input wire logic readback_o,
    // Controls
    input wire logic mixer_powerdown_o,
    input wire logic test_buffer_powerdown_o,
    input wire logic filter_powerdown_o,
    input wire logic offset_cal_powerdown_o,
    input wire logic [4:0] baseband_gain_code_o,
    input wire logic [7:0] corner_freq_code_o,
    input wire logic detector_resistor_bypass_o,
    input wire logic detector_capacitor_bypass_o,
    input wire demod_pkg::det_bw_t detector_bw_o,
    input wire logic fast_gain_enable_o,
    input wire logic gain_step_double_o,
    input wire logic osc_test_enable_o,
    input wire logic output_atten_enable_o,
    input wire logic autocal_start_o
);
    import demod_pkg::*;
    logic [7:0] since_load;
    logic [7:0] next_since_load;

    // Cycles since strobe was high, saturating so old loads never wrap
    always_comb
    begin
        next_since_load = since_load;
        if (word_load_edge_i)
            next_since_load = 8'h00;
        else if (since_load != 8'hff)
            next_since_load = since_load + 8'h01;
    end

    always_ff @(posedge clk_i)
    begin
        since_load <= sys_rst_i ? 8'hff : next_since_load;
    end

    // ==========================================
    // Properties
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);
    sequence s_held_reset;
        sys_rst_i [*2];
    endsequence
    sequence s_done_edge;
        $rose(cal_done_i) && autocal_start_o;
    endsequence

    AST_RESET_POWER: assert property (disable iff (1'b0) sys_rst_i |=>
        !mixer_powerdown_o && test_buffer_powerdown_o && !filter_powerdown_o
        && offset_cal_powerdown_o) else $error("power controls wrong in reset");
    AST_RESET_MODES: assert property (disable iff (1'b0) sys_rst_i |=>
        corner_freq_code_o == 8'h80 && !autocal_start_o && !{fast_gain_enable_o,
        gain_step_double_o, osc_test_enable_o, output_atten_enable_o,
        detector_resistor_bypass_o, detector_capacitor_bypass_o})
        else $error("mode controls wrong in reset");
    AST_RESET_GAIN: assert property (disable iff (1'b0) s_held_reset |=>
        baseband_gain_code_o == 5'h0f && detector_bw_o == DET_BW_10MHZ)
        else $error("gain or bandwidth wrong in reset");
    AST_GAIN_CLAMP: assert property (baseband_gain_code_o <= 5'h18)
        else $error("gain code above limit");
    AST_BW_DECODE: assert property (detector_bw_o ==
        {$past(detector_capacitor_bypass_o) && $past(detector_resistor_bypass_o),
        $past(detector_resistor_bypass_o)}) else $error("bandwidth decode wrong");
    AST_AUTOCAL_CLEAR: assert property (s_done_edge |-> ##[1:7] !autocal_start_o)
        else $error("autocal bit not cleared");
    AST_NO_LOAD_NO_CHANGE: assert property ($changed({mixer_powerdown_o,
        test_buffer_powerdown_o, filter_powerdown_o, offset_cal_powerdown_o,
        corner_freq_code_o, fast_gain_enable_o, output_atten_enable_o,
        osc_test_enable_o}) |-> since_load < 8'h08) else $error("change without load");
    AST_READBACK_QUIET: assert property (readback_o && !osc_test_enable_o
        |-> since_load < 8'h78) else $error("readback active without request");
endmodule

bind demod_setup_registers demod_setup_registers_monitor mon (.*);

// ===== serial_host_model.sv
`timescale 1ns/10ps

// ==========================================
// Host end of the four-wire link
module serial_host_model (
    // Link pins
    output logic ser_clk_o,
    output logic ser_data_o,
    output logic word_load_edge_o,
    input wire logic readback_i
);
    // Idle link, clock parked low
    initial
    begin
        ser_clk_o = 1'b0;
        ser_data_o = 1'b1;
        word_load_edge_o = 1'b0;
    end

    // Link clock runs only inside frames and the t_reset bursts
    task automatic pulse(input int n);
        repeat (n)
        begin
            #15 ser_clk_o = 1'b1;
            #15 ser_clk_o = 1'b0;
        end
    endtask

    // Word LSB first, then strobe; no clocks while device samples
    task automatic write_word(input logic [31:0] w);
        for (int i = 0; i < 32; i++)
        begin
            ser_data_o = w[i];
            pulse(1);
        end
        ser_data_o = ~ser_data_o; // Released line, not the last bit
        word_load_edge_o = 1'b1;
        #200 word_load_edge_o = 1'b0;
        #200;
    endtask

    // Readback request, idle edge, 32 bits, closing edge
    task automatic read_word(input logic [2:0] sel, output logic [31:0] r);
        write_word({24'h000000, sel, 5'h08});
        #60;
        pulse(1);
        for (int i = 0; i < 32; i++)
        begin
            #15 ser_clk_o = 1'b1;
            #15 r[i] = readback_i;
            ser_clk_o = 1'b0;
        end
        pulse(1);
    endtask
endmodule

// ===== demod_setup_registers_test.sv
`include "demod_consts.svh"
`timescale 1ns/10ps

module demod_setup_registers_test;
    import demod_pkg::*;
    // ==========================================
    // Pins and counters
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic cal_done_i = 1'b0;
    logic osc_i = 1'b0;
    logic ser_clk_i, ser_data_i, word_load_edge_i, readback_o;
    logic mixer_powerdown_o, test_buffer_powerdown_o, filter_powerdown_o;
    logic offset_cal_powerdown_o, detector_resistor_bypass_o, detector_capacitor_bypass_o;
    logic fast_gain_enable_o, gain_step_double_o, osc_test_enable_o;
    logic output_atten_enable_o, autocal_start_o;
    logic [4:0] baseband_gain_code_o;
    logic [7:0] corner_freq_code_o;
    det_bw_t detector_bw_o;
    logic [31:0] seen;
    logic [31:0] words [3] = '{32'h9bff8129, 32'h44000ec9, 32'h0700f009};
    logic [4:0] bad [4] = '{5'h01, 5'h0b, 5'h11, 5'h19};
    int mismatches = 0;
    int tests_run = 0;

    // Clock
    always #20 clk_i = ~clk_i;

    demod_setup_registers dut (.*);
    serial_host_model host (.ser_clk_o(ser_clk_i), .ser_data_o(ser_data_i),
        .word_load_edge_o(word_load_edge_i), .readback_i(readback_o));

    // ==========================================
    // Shared checks
    task automatic check(input string n, input logic [31:0] e, input logic [31:0] s);
        tests_run++;
        if (s !== e)
        begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic check_word(input logic [31:0] w);
        check("mixer", w[5], mixer_powerdown_o);
        check("buffer", w[7], test_buffer_powerdown_o);
        check("filter", w[8], filter_powerdown_o);
        check("offset", w[10], offset_cal_powerdown_o);
        check("gain", w[16:12], baseband_gain_code_o);
        check("corner", w[24:17], corner_freq_code_o);
        check("det", w[26:25], {detector_capacitor_bypass_o, detector_resistor_bypass_o});
        check("bw", {w[26] & w[25], w[25]}, detector_bw_o);
        check("modes", {w[31], w[29:27]}, {output_atten_enable_o, osc_test_enable_o,
            gain_step_double_o, fast_gain_enable_o});
    endtask

    task automatic complete_run;
        if (mismatches == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ==========================================
    // Scenarios
    task automatic t_reset;
        @(negedge clk_i) sys_rst_i = 1'b1;
        host.pulse(4);
        repeat (9) @(negedge clk_i);
        sys_rst_i = 1'b0;
        check_word(`SETUP_ONE_RST);
        check("autocal", 1'b0, autocal_start_o);
        check("readback", 1'b0, readback_o);
        // Link reset lingers until the serial clock has run a few edges
        host.pulse(4);
        host.read_word(3'h1, seen);
        check("read setup", `SETUP_ONE_RST, seen);
        host.read_word(3'h2, seen);
        check("read cal", `CAL_SETUP_RST, seen);
    endtask

    task automatic t_fields;
        for (int i = 0; i < 3; i++)
        begin
            host.write_word(words[i]);
            check_word(words[i]);
            host.read_word(3'h1, seen);
            check("read word", words[i], seen);
        end
    endtask

    // Foreign addresses must leave the setup word alone
    task automatic t_addr;
        foreach (bad[i])
        begin
            host.write_word({~words[2][31:5], bad[i]});
            check_word(words[2]);
        end
    endtask

    task automatic t_autocal;
        host.write_word(`CAL_SETUP_RST | 32'h20);
        check("autocal set", 1'b1, autocal_start_o);
        check_word(words[2]);
        @(negedge clk_i) cal_done_i = 1'b1;
        repeat (8) @(negedge clk_i);
        check("autocal done", 1'b0, autocal_start_o);
        cal_done_i = 1'b0;
        host.read_word(3'h2, seen);
        check("read cal", `CAL_SETUP_RST, seen);
    endtask

    // Oscillator level replaces readback data
    task automatic t_osc;
        host.write_word(words[2] | 32'h20000000);
        @(negedge clk_i) osc_i = 1'b1;
        host.read_word(3'h1, seen);
        check("osc high", 32'hffffffff, seen);
        @(negedge clk_i) osc_i = 1'b0;
        host.read_word(3'h1, seen);
        check("osc low", 32'h00000000, seen);
        host.write_word(words[2]);
        check_word(words[2]);
    endtask

    // ==========================================
    // Sequence and watchdog
    initial
    begin
        t_reset();
        t_fields();
        t_addr();
        t_autocal();
        t_osc();
        t_reset();
        complete_run();
    end

    initial
    begin
        #400000;
        mismatches++;
        complete_run();
    end
endmodule
